// *** logic/mmd_decoder.sv ***
// Memory map decoder, RAM, stack pointer and I/O register window
`timescale 1ns/100ps
`include "mmd_defines.svh"
module mmd_decoder
  import mmd_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // CPU memory bus
  input  wire logic [12:0] cpu_addr,
  input  wire logic        cpu_rd,
  input  wire logic        cpu_wr,
  input  wire logic [7:0]  cpu_wdata,
  output logic      [7:0]  cpu_rdata,
  // Stack pointer control
  input  wire mmd_sp_op_t  sp_op,
  output logic      [7:0]  stack_ptr,
  // Watchdog service
  output logic             watchdog_clear,
  // Port pins, data and direction
  output logic      [7:0]  port_a_out,
  output logic      [7:0]  port_a_oe,
  input  wire logic [7:0]  port_a_in,
  output logic      [7:0]  port_b_out,
  output logic      [7:0]  port_b_oe,
  input  wire logic [7:0]  port_b_in,
  output logic      [7:0]  port_c_out,
  output logic      [7:0]  port_c_oe,
  input  wire logic [7:0]  port_c_in,
  output logic      [7:0]  port_d_out,
  output logic      [7:0]  port_d_oe,
  input  wire logic [7:0]  port_d_in,
  // Serial port register side
  output logic      [7:0]  serial_control,
  input  wire logic [7:0]  serial_status,
  input  wire logic [7:0]  serial_shift_rdata,
  output logic             serial_shift_wr,
  output logic             serial_shift_rd,
  // Timer register side
  output logic      [7:0]  timer_control,
  input  wire logic [7:0]  timer_status,
  input  wire logic [15:0] capture_value,
  input  wire logic [15:0] free_counter,
  output logic      [15:0] compare_value,
  output logic      [4:0]  timer_access_ofs,
  output logic             timer_rd,
  output logic             timer_wr
);

  // ************************************************************
  // Address decode
  // ************************************************************
  mmd_region_t region;           // Region of current address
  logic        in_io;            // Register window hit
  logic        in_ram;           // RAM hit
  logic        in_stack;         // Stack part of RAM
  logic        in_rom;           // User ROM hit
  logic        in_self;          // Self-check ROM hit
  logic        in_vec;           // Vector ROM hit
  logic        is_wdog;          // Watchdog service address
  logic [4:0]  io_ofs;           // Offset inside register window

  // Full 13-bit compare, no aliasing across the space
  assign in_io    = (cpu_addr <= `MMD_IO_LAST);
  assign in_ram   = (cpu_addr >= `MMD_RAM_FIRST) &&
                    (cpu_addr <= `MMD_RAM_LAST);
  assign in_stack = (cpu_addr >= `MMD_STACK_FIRST) &&
                    (cpu_addr <= `MMD_STACK_LAST);
  // User ROM block plus the spare area up to the vectors
  assign in_rom   = ((cpu_addr >= `MMD_ROM_FIRST) && (cpu_addr <= `MMD_ROM_LAST)) ||
                    ((cpu_addr > `MMD_SELF_LAST) && (cpu_addr < `MMD_VEC_FIRST));
  assign in_self  = (cpu_addr >= `MMD_SELF_FIRST) &&
                    (cpu_addr <= `MMD_SELF_LAST);
  assign in_vec   = (cpu_addr >= `MMD_VEC_FIRST);
  assign is_wdog  = (cpu_addr == `MMD_WDOG_ADDR);
  assign io_ofs   = cpu_addr[4:0];

  // Region priority chain
  assign region = in_io   ? MMD_REG_IO   :
                  in_ram  ? MMD_REG_RAM  :
                  in_self ? MMD_REG_SELF :
                  in_vec  ? MMD_REG_VEC  :
                  in_rom  ? MMD_REG_ROM  : MMD_REG_NONE;

  // ************************************************************
  // ROM arrays
  // ************************************************************
  // Mask-programmed contents; zero here, replaced at tape-out
  logic [7:0] rom_mem [0:`MMD_ROM_BYTES-1]; // User ROM with vectors
  logic [7:0] self_mem [0:239];             // Self-check ROM
  logic [12:0] rom_idx;                     // Index into user ROM
  logic [7:0]  self_idx;                    // Index into self-check ROM

  // Vectors sit at the last eight user ROM bytes, high byte first
  assign rom_idx  = in_vec ? 13'(cpu_addr - `MMD_VEC_FIRST + 13'(`MMD_ROM_BYTES - 8))
                           : (cpu_addr > `MMD_SELF_LAST)
                             ? 13'(cpu_addr - `MMD_SELF_LAST - 13'h0001 + 13'h1000)
                             : 13'(cpu_addr - `MMD_ROM_FIRST);
  assign self_idx = 8'(cpu_addr - `MMD_SELF_FIRST);

  // Constant contents
  genvar gi;
  generate
    for (gi = 0; gi < `MMD_ROM_BYTES; gi++) begin : g_rom
      assign rom_mem[gi] = 8'h00;
    end
    for (gi = 0; gi < 240; gi++) begin : g_self
      assign self_mem[gi] = 8'h00;
    end
  endgenerate

  // ************************************************************
  // Static RAM
  // ************************************************************
  logic [7:0] ram_mem [0:175];   // 176 bytes, no refresh needed
  logic [7:0] ram_idx;           // Index into RAM
  logic       ram_we;            // RAM write strobe

  assign ram_idx = 8'(cpu_addr - `MMD_RAM_FIRST);
  assign ram_we  = cpu_wr && (region == MMD_REG_RAM);

  // RAM write; stack bytes share the same array
  always_ff @(posedge mclk) begin
    if (ram_we) begin
      ram_mem[ram_idx] <= cpu_wdata;
    end
  end

  // ************************************************************
  // Stack pointer
  // ************************************************************
  logic [7:0] sp_reg;            // Stack pointer
  logic [7:0] sp_next;           // Next stack pointer

  // Post-decrement on push, pre-increment on pull; wraps in stack
  assign sp_next = (sp_op == MMD_SP_PUSH) ? {2'b11, 6'(sp_reg[5:0] - 6'd1)} :
                   (sp_op == MMD_SP_PULL) ? {2'b11, 6'(sp_reg[5:0] + 6'd1)} :
                   (sp_op == MMD_SP_LOAD) ? `MMD_SP_RESET : sp_reg;
  // CPU addresses the stack byte with stack_ptr for push, sp_next for pull

  // Stack pointer register
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sp_reg <= `MMD_SP_RESET;
    end else begin
      sp_reg <= sp_next;
    end
  end
  assign stack_ptr = sp_reg;

  // ************************************************************
  // Register window write decode
  // ************************************************************
  logic io_wr;                   // Write into register window
  logic [7:0] pa_data_reg, pb_data_reg, pc_data_reg, pd_data_reg;
  logic [7:0] pa_dir_reg, pb_dir_reg, pc_dir_reg, pd_dir_reg;
  logic [7:0] ser_ctl_reg;       // Serial control
  logic [7:0] tmr_ctl_reg;       // Timer control
  logic [7:0] cmp_hi_reg;        // Compare high byte
  logic [7:0] cmp_lo_reg;        // Compare low byte
  logic       wdog_reg;          // Watchdog clear pulse

  assign io_wr = cpu_wr && in_io;

  // Register writes; unmapped offsets fall through and are dropped
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pa_data_reg <= 8'h00;
      pb_data_reg <= 8'h00;
      pc_data_reg <= 8'h00;
      pd_data_reg <= 8'h00;
      pa_dir_reg  <= 8'h00;
      pb_dir_reg  <= 8'h00;
      pc_dir_reg  <= 8'h00;
      pd_dir_reg  <= 8'h00;
      ser_ctl_reg <= 8'h00;
      tmr_ctl_reg <= 8'h00;
      cmp_hi_reg  <= 8'h00;
      cmp_lo_reg  <= 8'h00;
    end else if (io_wr) begin
      if (io_ofs == `MMD_OFS_PA_DATA) begin
        pa_data_reg <= cpu_wdata;
      end else if (io_ofs == `MMD_OFS_PB_DATA) begin
        pb_data_reg <= cpu_wdata & `MMD_PB_MASK;
      end else if (io_ofs == `MMD_OFS_PC_DATA) begin
        pc_data_reg <= cpu_wdata;
      end else if (io_ofs == `MMD_OFS_PD_DATA) begin
        pd_data_reg <= cpu_wdata & `MMD_PD_DIR_MASK;
      end else if (io_ofs == `MMD_OFS_PA_DIR) begin
        pa_dir_reg  <= cpu_wdata;
      end else if (io_ofs == `MMD_OFS_PB_DIR) begin
        pb_dir_reg  <= cpu_wdata & `MMD_PB_MASK;
      end else if (io_ofs == `MMD_OFS_PC_DIR) begin
        pc_dir_reg  <= cpu_wdata;
      end else if (io_ofs == `MMD_OFS_PD_DIR) begin
        pd_dir_reg  <= cpu_wdata & `MMD_PD_DIR_MASK;
      end else if (io_ofs == `MMD_OFS_SER_CTL) begin
        ser_ctl_reg <= cpu_wdata & `MMD_SER_CTL_MASK;
      end else if (io_ofs == `MMD_OFS_TMR_CTL) begin
        tmr_ctl_reg <= cpu_wdata & `MMD_TMR_CTL_MASK;
      end else if (io_ofs == `MMD_OFS_CMP_HI) begin
        cmp_hi_reg  <= cpu_wdata;
      end else if (io_ofs == `MMD_OFS_CMP_LO) begin
        cmp_lo_reg  <= cpu_wdata;
      end
    end
  end

  // Watchdog service: bit 0 written as zero clears the counter
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wdog_reg <= 1'b0;
    end else begin
      wdog_reg <= cpu_wr && is_wdog && !cpu_wdata[`MMD_WDOG_BIT];
    end
  end

  // ************************************************************
  // Read data path
  // ************************************************************
  logic [7:0] io_rdata;          // Register window read value
  logic [7:0] mem_rdata;         // Selected read value
  logic [7:0] rdata_reg;         // Registered read data
  logic [7:0] pb_pins;           // Port B read, lower bits zero
  logic [7:0] pd_pins;           // Port D read

  // Output pins read back the latch, inputs read the pin
  assign pb_pins = ((pb_data_reg & pb_dir_reg) | (port_b_in & ~pb_dir_reg)) & `MMD_PB_MASK;
  assign pd_pins = ((pd_data_reg & pd_dir_reg) | (port_d_in & ~pd_dir_reg))
                   & `MMD_PD_DATA_MASK;

  // Register window read mux; reserved offsets read zero
  assign io_rdata =
    (io_ofs == `MMD_OFS_PA_DATA)  ? ((pa_data_reg & pa_dir_reg) | (port_a_in & ~pa_dir_reg)) :
    (io_ofs == `MMD_OFS_PB_DATA)  ? pb_pins :
    (io_ofs == `MMD_OFS_PC_DATA)  ? ((pc_data_reg & pc_dir_reg) | (port_c_in & ~pc_dir_reg)) :
    (io_ofs == `MMD_OFS_PD_DATA)  ? pd_pins :
    (io_ofs == `MMD_OFS_PA_DIR)   ? pa_dir_reg :
    (io_ofs == `MMD_OFS_PB_DIR)   ? (pb_dir_reg | ~`MMD_PB_MASK) :
    (io_ofs == `MMD_OFS_PC_DIR)   ? pc_dir_reg :
    (io_ofs == `MMD_OFS_PD_DIR)   ? pd_dir_reg :
    (io_ofs == `MMD_OFS_SER_CTL)  ? ser_ctl_reg :
    (io_ofs == `MMD_OFS_SER_STAT) ? serial_status :
    (io_ofs == `MMD_OFS_SER_DATA) ? serial_shift_rdata :
    (io_ofs == `MMD_OFS_TMR_CTL)  ? tmr_ctl_reg :
    (io_ofs == `MMD_OFS_TMR_STAT) ? timer_status :
    (io_ofs == `MMD_OFS_CAP_HI)   ? capture_value[15:8] :
    (io_ofs == `MMD_OFS_CAP_LO)   ? capture_value[7:0] :
    (io_ofs == `MMD_OFS_CMP_HI)   ? cmp_hi_reg :
    (io_ofs == `MMD_OFS_CMP_LO)   ? cmp_lo_reg :
    ((io_ofs == `MMD_OFS_CNT_HI) || (io_ofs == `MMD_OFS_SHD_HI)) ? free_counter[15:8] :
    ((io_ofs == `MMD_OFS_CNT_LO) || (io_ofs == `MMD_OFS_SHD_LO)) ? free_counter[7:0] :
    8'h00;

  // Memory read mux; watchdog address reads the ROM byte beneath it
  assign mem_rdata = (region == MMD_REG_IO)   ? io_rdata :
                     (region == MMD_REG_RAM)  ? ram_mem[ram_idx] :
                     (region == MMD_REG_SELF) ? self_mem[self_idx] :
                     ((region == MMD_REG_VEC) || (region == MMD_REG_ROM))
                                              ? rom_mem[rom_idx] :
                     8'h00;

  // Read data flop, one cycle after the read strobe
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_reg <= 8'h00;
    end else if (cpu_rd) begin
      rdata_reg <= mem_rdata;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign cpu_rdata        = rdata_reg;
  assign watchdog_clear   = wdog_reg;
  assign port_a_out       = pa_data_reg;
  assign port_a_oe        = pa_dir_reg;
  assign port_b_out       = pb_data_reg;
  assign port_b_oe        = pb_dir_reg;
  assign port_c_out       = pc_data_reg;
  assign port_c_oe        = pc_dir_reg;
  assign port_d_out       = pd_data_reg;
  assign port_d_oe        = pd_dir_reg;
  assign serial_control   = ser_ctl_reg;
  assign timer_control    = tmr_ctl_reg;
  assign compare_value    = {cmp_hi_reg, cmp_lo_reg};
  // Side-effect strobes for the timer and serial blocks
  assign timer_access_ofs = io_ofs;
  assign timer_rd         = cpu_rd && in_io && (io_ofs >= `MMD_OFS_TMR_CTL);
  assign timer_wr         = io_wr && (io_ofs >= `MMD_OFS_TMR_CTL);
  assign serial_shift_wr  = io_wr && (io_ofs == `MMD_OFS_SER_DATA);
  assign serial_shift_rd  = cpu_rd && in_io && (io_ofs == `MMD_OFS_SER_DATA);

endmodule : mmd_decoder

// *** logic/mmd_defines.svh ***
// Address map constants for the memory map decoder
`ifndef MMD_DEFINES_SVH
`define MMD_DEFINES_SVH
`define MMD_ADDR_W        13
`define MMD_IO_LAST       13'h001F
`define MMD_RAM_FIRST     13'h0050
`define MMD_RAM_LAST      13'h00FF
`define MMD_STACK_FIRST   13'h00C0
`define MMD_STACK_LAST    13'h00FF
`define MMD_ROM_FIRST     13'h0F00
`define MMD_ROM_LAST      13'h1EFF
`define MMD_ROM_BYTES     4160
`define MMD_SELF_FIRST    13'h1F00
`define MMD_SELF_LAST     13'h1FEF
`define MMD_WDOG_ADDR     13'h1FF0
`define MMD_VEC_FIRST     13'h1FF8
`define MMD_VEC_TIMER     13'h1FF8
`define MMD_VEC_EXT       13'h1FFA
`define MMD_VEC_SWI       13'h1FFC
`define MMD_VEC_RESET     13'h1FFE
`define MMD_OFS_PA_DATA   5'h00
`define MMD_OFS_PB_DATA   5'h01
`define MMD_OFS_PC_DATA   5'h02
`define MMD_OFS_PD_DATA   5'h03
`define MMD_OFS_PA_DIR    5'h04
`define MMD_OFS_PB_DIR    5'h05
`define MMD_OFS_PC_DIR    5'h06
`define MMD_OFS_PD_DIR    5'h07
`define MMD_OFS_SER_CTL   5'h0A
`define MMD_OFS_SER_STAT  5'h0B
`define MMD_OFS_SER_DATA  5'h0C
`define MMD_OFS_TMR_CTL   5'h12
`define MMD_OFS_TMR_STAT  5'h13
`define MMD_OFS_CAP_HI    5'h14
`define MMD_OFS_CAP_LO    5'h15
`define MMD_OFS_CMP_HI    5'h16
`define MMD_OFS_CMP_LO    5'h17
`define MMD_OFS_CNT_HI    5'h18
`define MMD_OFS_CNT_LO    5'h19
`define MMD_OFS_SHD_HI    5'h1A
`define MMD_OFS_SHD_LO    5'h1B
`define MMD_PB_MASK       8'hE0
`define MMD_PD_DATA_MASK  8'hA0
`define MMD_PD_DIR_MASK   8'h20
`define MMD_SER_CTL_MASK  8'h50
`define MMD_TMR_CTL_MASK  8'hE3
`define MMD_SP_RESET      8'hFF
`define MMD_WDOG_BIT      0
`endif

// *** logic/mmd_pkg.sv ***
// Types shared by the memory map decoder
package mmd_pkg;
  // Region selected by the current address
  typedef enum logic [2:0] {
    MMD_REG_IO,
    MMD_REG_RAM,
    MMD_REG_ROM,
    MMD_REG_SELF,
    MMD_REG_VEC,
    MMD_REG_NONE
  } mmd_region_t;
  // Stack pointer operation request
  typedef enum logic [1:0] {
    MMD_SP_HOLD,
    MMD_SP_PUSH,
    MMD_SP_PULL,
    MMD_SP_LOAD
  } mmd_sp_op_t;
endpackage : mmd_pkg

// *** testbench/mcu_memory_map_decoder_test.sv ***
// Self-checking bench for the memory map decoder
`timescale 1ns/100ps
module mcu_memory_map_decoder_test;
  import mmd_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic        mclk = 1'b0;     // 200 MHz clock
  logic        reset_n = 1'b0;  // Async reset, low
  logic [12:0] cpu_addr;
  logic        cpu_rd, cpu_wr;
  logic [7:0]  cpu_wdata, cpu_rdata, stack_ptr, port_a_out, port_a_oe, port_b_oe;
  logic [7:0]  ser_st, ser_sh, tmr_st, d, v;
  logic [15:0] cap, cnt, compare_value;
  logic [31:0] pins;            // All four port input buses
  logic        watchdog_clear;
  mmd_sp_op_t  sp_op;
  int          bad_count = 0;
  int          total_checks = 0;
  logic [7:0]  ram [int];       // Reference contents of written RAM
  logic [7:0]  sp_exp;
  always #2.5 mclk = ~mclk;
  // ****************************************
  // Design and CPU model
  // ****************************************
  mmd_decoder uut (.mclk(mclk), .reset_n(reset_n), .cpu_addr(cpu_addr), .cpu_rd(cpu_rd),
    .cpu_wr(cpu_wr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .sp_op(sp_op),
    .stack_ptr(stack_ptr), .watchdog_clear(watchdog_clear), .port_a_out(port_a_out),
    .port_a_oe(port_a_oe), .port_a_in(pins[7:0]), .port_b_out(), .port_b_oe(port_b_oe),
    .port_b_in(pins[15:8]), .port_c_out(), .port_c_oe(), .port_c_in(pins[23:16]),
    .port_d_out(), .port_d_oe(), .port_d_in(pins[31:24]), .serial_control(),
    .serial_status(ser_st), .serial_shift_rdata(ser_sh), .serial_shift_wr(),
    .serial_shift_rd(), .timer_control(), .timer_status(tmr_st), .capture_value(cap),
    .free_counter(cnt), .compare_value(compare_value), .timer_access_ofs(),
    .timer_rd(), .timer_wr());
  mmd_cpu_model cpu (.mclk(mclk), .cpu_addr(cpu_addr), .cpu_rd(cpu_rd), .cpu_wr(cpu_wr),
    .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata));
  // ****************************************
  // Reference model and reporting
  // ****************************************
  // Readback of a written byte: writable bits, fixed bits, zero elsewhere
  function automatic logic [7:0] shape(input logic [12:0] a, input logic [7:0] w);
    case (a)
      13'h04, 13'h06, 13'h16, 13'h17: return w;
      13'h05:  return (w & 8'hE0) | 8'h1F;  // Missing pins read as outputs
      13'h07:  return w & 8'h20;
      13'h0A:  return w & 8'h50;
      13'h12:  return w & 8'hE3;
      default: return 8'h00;                // Gaps and ROM (blank) read zero
    endcase
  endfunction : shape
  // Byte compare, counted
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_byte
  // Single exit point of the run
  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  // Watchdog against a hung bus at 20000 cycles, far beyond the fewer than 700 cycles used
  initial begin
    #100000;
    bad_count++;
    complete_run();
  end
  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    logic [12:0] regs [$] = '{13'h04, 13'h05, 13'h06, 13'h07, 13'h0A, 13'h12, 13'h16,
      13'h17, 13'h08, 13'h09, 13'h0D, 13'h11, 13'h1C, 13'h1F, 13'h20, 13'h4F, 13'h0F00,
      13'h1EFF, 13'h1F00, 13'h1FEF, 13'h1FF7, 13'h1FF8, 13'h1FF9, 13'h1FFA, 13'h1FFB,
      13'h1FFC, 13'h1FFD, 13'h1FFE, 13'h1FFF};
    void'($urandom(32'h525c));
    pins   = $urandom;
    ser_st = {2'($urandom), 6'h00};  // Only the two flag bits are live
    ser_sh = 8'($urandom);
    tmr_st = {3'($urandom), 5'h00};  // Only the three flag bits are live
    cap    = 16'($urandom);
    cnt    = 16'($urandom);
    sp_op  = MMD_SP_HOLD;
    repeat (5) @(negedge mclk);
    reset_n = 1'b1;
    check_byte(stack_ptr, 8'hFF);
    check_byte(port_a_oe, 8'h00);
    // Write then read each direction and control register, and the end addresses of the gaps and ROM areas
    foreach (regs[i]) begin
      v = 8'($urandom);
      cpu.write_byte(regs[i], v);
      cpu.read_byte(regs[i], d);
      check_byte(d, shape(regs[i], v));
    end
    // Pin-side outputs follow the registers
    cpu.write_byte(13'h0016, 8'hA5);
    cpu.write_byte(13'h0017, 8'h3C);
    check_byte(compare_value[15:8], 8'hA5);
    check_byte(compare_value[7:0], 8'h3C);
    cpu.write_byte(13'h0004, 8'hFF);
    cpu.write_byte(13'h0000, 8'h5A);
    check_byte(port_a_oe, 8'hFF);
    check_byte(port_a_out, 8'h5A);
    cpu.write_byte(13'h0005, 8'hFF);
    check_byte(port_b_oe & 8'hE0, 8'hE0);
    cpu.read_byte(13'h0001, d);
    check_byte(d & 8'h1F, 8'h00);
    // Status and counter values from the other blocks
    cpu.read_byte(13'h000B, d);
    check_byte(d, ser_st);
    cpu.read_byte(13'h000C, d);
    check_byte(d, ser_sh);
    cpu.write_byte(13'h000C, 8'h77);  // Exercises the shift data write strobe
    cpu.read_byte(13'h0013, d);
    check_byte(d, tmr_st);
    cpu.read_byte(13'h0014, d);
    check_byte(d, cap[15:8]);
    cpu.read_byte(13'h0015, d);
    check_byte(d, cap[7:0]);
    for (int a = 13'h18; a < 13'h1C; a++) begin
      cpu.read_byte(13'(a), d);
      check_byte(d, a[0] ? cnt[7:0] : cnt[15:8]);
    end
    // RAM below the stack holds data, stack ends touched once each
    for (int a = 13'h50; a < 13'h100; a++) begin
      if (a < 13'hC0 || a == 13'hC0 || a == 13'hFF) begin
        ram[a] = 8'($urandom);
        cpu.write_byte(13'(a), ram[a]);
      end
    end
    foreach (ram[a]) begin
      cpu.read_byte(13'(a), d);
      check_byte(d, ram[a]);
    end
    // Watchdog service: zero in bit 0 clears, one does not
    cpu.write_byte(13'h1FF0, 8'hFE);
    check_byte({7'h00, watchdog_clear}, 8'h01);
    @(negedge mclk);
    check_byte({7'h00, watchdog_clear}, 8'h00);
    cpu.write_byte(13'h1FF0, 8'h01);
    check_byte({7'h00, watchdog_clear}, 8'h00);
    // Pushes past the bottom of the stack wrap, then pulls climb back
    sp_exp = stack_ptr;
    for (int i = 0; i < 68; i++) begin
      sp_op = (i < 66) ? MMD_SP_PUSH : MMD_SP_PULL;
      @(negedge mclk);
      sp_exp = (i < 66) ? {2'b11, sp_exp[5:0] - 6'd1} : {2'b11, sp_exp[5:0] + 6'd1};
      check_byte(stack_ptr, sp_exp);
    end
    // Reload puts the pointer back at the top of the stack
    sp_op = MMD_SP_LOAD;
    @(negedge mclk);
    check_byte(stack_ptr, 8'hFF);
    sp_op = MMD_SP_HOLD;
    repeat (2) @(negedge mclk);
    complete_run();
  end
endmodule : mcu_memory_map_decoder_test

// *** testbench/mmd_cpu_model.sv ***
// CPU core model that issues byte reads and writes to the decoder
`timescale 1ns/100ps
module mmd_cpu_model (
  // Clock
  input  wire logic        mclk,
  // Memory bus towards the decoder
  output logic      [12:0] cpu_addr,
  output logic             cpu_rd,
  output logic             cpu_wr,
  output logic      [7:0]  cpu_wdata,
  input  wire logic [7:0]  cpu_rdata
);
  // ****************************************
  // Bus cycles
  // ****************************************
  // Idle bus from time zero
  initial begin
    cpu_addr  = 13'h0000;
    cpu_rd    = 1'b0;
    cpu_wr    = 1'b0;
    cpu_wdata = 8'h00;
  end
  // One write, strobe held across exactly one rising edge
  task automatic write_byte(input logic [12:0] a, input logic [7:0] d);
    @(negedge mclk);
    cpu_addr  = a;
    cpu_wdata = d;
    cpu_wr    = 1'b1;
    @(negedge mclk);
    cpu_wr    = 1'b0;
    cpu_wdata = ~d;  // Released data never shows the stale byte
    cpu_addr  = ~a;
  endtask : write_byte
  // One read, data taken a cycle after the strobe edge
  task automatic read_byte(input logic [12:0] a, output logic [7:0] d);
    @(negedge mclk);
    cpu_addr = a;
    cpu_rd   = 1'b1;
    @(negedge mclk);
    cpu_rd   = 1'b0;
    cpu_addr = ~a;
    d        = cpu_rdata;
  endtask : read_byte
endmodule : mmd_cpu_model

// *** testbench/mmd_decoder_props.sv ***
// Concurrent checks on the memory map decoder ports
`timescale 1ns/100ps
module mmd_decoder_props
  import mmd_pkg::*;
(
  // Clock and reset
  input wire logic        mclk,
  input wire logic        reset_n,
  // CPU bus
  input wire logic [12:0] cpu_addr,
  input wire logic        cpu_rd,
  input wire logic        cpu_wr,
  input wire logic [7:0]  cpu_wdata,
  input wire logic [7:0]  cpu_rdata,
  // Stack, watchdog and serial strobe
  input wire mmd_sp_op_t  sp_op,
  input wire logic [7:0]  stack_ptr,
  input wire logic        watchdog_clear,
  input wire logic        serial_shift_wr
);
  // ****************************************
  // Decoded causes
  // ****************************************
  wire       wd_hit = cpu_wr && cpu_addr == 13'h1FF0 && !cpu_wdata[0];  // Service write
  wire [5:0] sp_low = stack_ptr[5:0];                                   // Offset in stack
  // Unused offsets inside the register window
  wire       gap_rd = cpu_rd && cpu_addr[12:5] == 8'h00 &&
                      cpu_addr[4:0] inside {5'h08, 5'h09, [5'h0D:5'h11], [5'h1C:5'h1F]};
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // ****************************************
  // Assertions
  // ****************************************
  wdog_pulse_a: assert property (wd_hit |=> watchdog_clear)
    else $error("watchdog clear missing");
  wdog_quiet_a: assert property (!wd_hit |=> !watchdog_clear)
    else $error("watchdog clear without service write");
  stack_push_a: assert property (sp_op == MMD_SP_PUSH |=> sp_low + 6'd1 == $past(sp_low))
    else $error("push did not decrement");
  stack_pull_a: assert property (sp_op == MMD_SP_PULL |=> sp_low == $past(sp_low) + 6'd1)
    else $error("pull did not increment");
  stack_hold_a: assert property (sp_op == MMD_SP_HOLD |=> $stable(stack_ptr))
    else $error("stack pointer moved on hold");
  stack_load_a: assert property (sp_op == MMD_SP_LOAD |=> stack_ptr == 8'hFF)
    else $error("stack pointer reload wrong");
  stack_range_a: assert property (stack_ptr[7:6] == 2'b11)
    else $error("stack pointer left stack region");
  rdata_hold_a: assert property (!cpu_rd |=> $stable(cpu_rdata))
    else $error("read data changed without read");
  gap_zero_a: assert property (gap_rd |=> cpu_rdata == 8'h00)
    else $error("unused location read nonzero");
  rom_read_a: assert property (cpu_rd && cpu_addr >= 13'h1F00 |=> cpu_rdata == 8'h00)
    else $error("top ROM read wrong");
  port_b_data_low_a: assert property (cpu_rd && cpu_addr == 13'h0001 |=> cpu_rdata[4:0] == 5'h00)
    else $error("second port low bits not zero");
  shift_wr_a: assert property (cpu_wr && cpu_addr == 13'h000C |-> serial_shift_wr)
    else $error("serial data write strobe missing");
endmodule : mmd_decoder_props
bind mmd_decoder mmd_decoder_props u_props (.mclk(mclk), .reset_n(reset_n),
  .cpu_addr(cpu_addr), .cpu_rd(cpu_rd), .cpu_wr(cpu_wr), .cpu_wdata(cpu_wdata),
  .cpu_rdata(cpu_rdata), .sp_op(sp_op), .stack_ptr(stack_ptr),
  .watchdog_clear(watchdog_clear), .serial_shift_wr(serial_shift_wr));
